// ==== src/nvm_program_once_erase_cmds.sv ====
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Read once fetches phrase into words 2..5; index must be 1 at launch
// - One-time area is eight 8-byte phrases, program once, never erased
// - One-time phrase index must lie in 0 to 7
// - Flash reads return invalid data during read once
// - Read once errors set verify status bit 1, fatal ones bits 1 and 0
// - Complete flag clear while a command runs, set when done
// - Program flash: block byte in word 0, address word 1, data 2..5
// - Program flash needs last index 3 or 5 at launch
// - Program address bits 1:0 must be zero
// - Program words must not run past end of flash block
// - Protected target sets protection flag, no programming
// - Program is read back; mismatch sets status bit 1
// - Program once: index word 1, data 2..5, last index 5
// - Program once checks phrase blank, then programs and verifies
// - Programming a used one-time phrase raises access error
// - Flash reads return invalid data during program once
// - Erase all erases and verifies all but the one-time area; last index must be 0
// - Successful erase all releases security
// - Erase all with any protection raises protection flag
// - Command not allowed in current mode raises access error
// - Global address bit 23 picks flash (0) or EEPROM (1)
module nvm_program_once_erase_cmds #(
  parameter logic [16:0] FLASH_SIZE = 17'h10000
) (
  input  wire logic                  I_CLK,
  input  wire logic                  I_RESETN,
  input  wire logic [4:0]            I_ADDRESS,
  input  wire logic                  I_READ,
  input  wire logic                  I_WRITE,
  input  wire logic [31:0]           I_WRITEDATA,
  input  wire logic [3:0]            I_BYTEENABLE,
  output logic      [31:0]           O_READDATA,
  output logic                       O_WAITREQUEST,
  output nvm_seq_pkg::arr_req_t      O_ARR,
  input  wire nvm_seq_pkg::arr_rsp_t I_ARR,
  input  wire logic [7:0]            I_CPU_RDATA,
  output logic      [7:0]            O_CPU_RDATA,
  output logic                       O_SECURED
);

  nvm_seq_pkg::ctl_t q;
  nvm_seq_pkg::ctl_t d;

  logic [7:0]  cmd;
  logic [23:0] gaddr;
  logic        is_ro;
  logic        is_pf;
  logic        is_po;
  logic        is_ea;
  logic        bad_ph;
  logic [16:0] end_addr;
  logic        past_end;
  logic        acc_c;
  logic        fpv_c;
  logic        wr_go;
  logic        launch;
  logic        ack;
  logic [31:0] bmask;

  assign cmd   = q.words[0][15:8];
  assign gaddr = {q.words[0][7:0], q.words[1]};
  assign is_ro = cmd == nvm_seq_pkg::CMD_READ_ONCE;
  assign is_pf = cmd == nvm_seq_pkg::CMD_PROG;
  assign is_po = cmd == nvm_seq_pkg::CMD_PROG_ONCE;
  assign is_ea = cmd == nvm_seq_pkg::CMD_ERASE_ALL;
  assign bad_ph = q.words[1] > nvm_seq_pkg::ONCE_LAST;
  assign end_addr = {1'b0, gaddr[15:0]} +
    ((q.idx == nvm_seq_pkg::IDX_5) ? nvm_seq_pkg::LW2_BYTES
                                   : nvm_seq_pkg::LW1_BYTES);
  assign past_end = end_addr > FLASH_SIZE;

  // Launch checks; protection is only judged when access is clean
  assign acc_c = q.cmd_dis
    | (is_ro & ((q.idx != nvm_seq_pkg::IDX_1) | bad_ph))
    | (is_pf & (((q.idx != nvm_seq_pkg::IDX_3) &
                 (q.idx != nvm_seq_pkg::IDX_5))
                | (gaddr[1:0] != 2'h0)
                | gaddr[nvm_seq_pkg::EEP_SEL_BIT]
                | (gaddr[22:16] != 7'h00)
                | past_end))
    | (is_po & ((q.idx != nvm_seq_pkg::IDX_5) | bad_ph))
    | (is_ea & (q.idx != nvm_seq_pkg::IDX_0))
    | ~(is_ro | is_pf | is_po | is_ea);
  assign fpv_c = ~acc_c & (
      (is_pf & (end_addr > q.prot_base))
    | (is_ea & ((q.prot_base != FLASH_SIZE) | q.eep_prot)));

  // Writes are dropped while a command runs
  assign wr_go  = I_WRITE & ~q.waitreq & q.ccf;
  // A launch with an error flag still set is ignored
  assign launch = wr_go & (I_ADDRESS == nvm_seq_pkg::A_STATUS)
    & I_BYTEENABLE[0] & I_WRITEDATA[nvm_seq_pkg::CCF_BIT]
    & ~q.access_error_flag & ~q.protection_violation_flag;
  assign ack   = q.arr.req & I_ARR.ack;
  assign bmask = {{8{I_BYTEENABLE[3]}}, {8{I_BYTEENABLE[2]}},
                  {8{I_BYTEENABLE[1]}}, {8{I_BYTEENABLE[0]}}};

  always_comb begin
    logic [31:0] rd;
    logic [31:0] nv;
    logic [31:0] wv;
    logic        mism;
    rd   = '0;
    nv   = '0;
    wv   = '0;
    mism = 1'b0;
    d    = q;
    d.waitreq = 1'b1;

    // Current image of the addressed register
    if (I_ADDRESS == nvm_seq_pkg::A_STATUS) begin
      rd[nvm_seq_pkg::CCF_BIT] = q.ccf;
      rd[nvm_seq_pkg::ACC_BIT] = q.access_error_flag;
      rd[nvm_seq_pkg::FPV_BIT] = q.protection_violation_flag;
      rd[1:0] = q.mgstat;
    end else if (I_ADDRESS == nvm_seq_pkg::A_INDEX) begin
      rd[2:0] = q.idx;
    end else if (I_ADDRESS == nvm_seq_pkg::A_OBJ_HI) begin
      if (q.idx <= nvm_seq_pkg::IDX_5) begin
        rd[7:0] = q.words[q.idx][15:8];
      end
    end else if (I_ADDRESS == nvm_seq_pkg::A_OBJ_LO) begin
      if (q.idx <= nvm_seq_pkg::IDX_5) begin
        rd[7:0] = q.words[q.idx][7:0];
      end
    end else if (I_ADDRESS == nvm_seq_pkg::A_CONFIG) begin
      rd[nvm_seq_pkg::DIS_BIT] = q.cmd_dis;
      rd[nvm_seq_pkg::EEP_BIT] = q.eep_prot;
    end else if (I_ADDRESS == nvm_seq_pkg::A_PROT) begin
      rd[16:0] = q.prot_base;
    end else if (I_ADDRESS == nvm_seq_pkg::A_SECURE) begin
      rd[0] = q.secured;
    end
    nv = (rd & ~bmask) | (I_WRITEDATA & bmask);
    wv = I_WRITEDATA & bmask;

    // One wait cycle, then the answer for one cycle
    if ((I_READ | I_WRITE) & q.waitreq) begin
      d.waitreq = 1'b0;
      d.rdata   = rd;
    end

    if (wr_go) begin
      if (I_ADDRESS == nvm_seq_pkg::A_STATUS) begin
        if (wv[nvm_seq_pkg::ACC_BIT]) begin
          d.access_error_flag = 1'b0;
        end
        if (wv[nvm_seq_pkg::FPV_BIT]) begin
          d.protection_violation_flag = 1'b0;
        end
      end else if (I_ADDRESS == nvm_seq_pkg::A_INDEX) begin
        d.idx = nv[2:0];
      end else if (I_ADDRESS == nvm_seq_pkg::A_OBJ_HI) begin
        if (q.idx <= nvm_seq_pkg::IDX_5) begin
          d.words[q.idx][15:8] = nv[7:0];
        end
      end else if (I_ADDRESS == nvm_seq_pkg::A_OBJ_LO) begin
        if (q.idx <= nvm_seq_pkg::IDX_5) begin
          d.words[q.idx][7:0] = nv[7:0];
        end
      end else if (I_ADDRESS == nvm_seq_pkg::A_CONFIG) begin
        d.cmd_dis  = nv[nvm_seq_pkg::DIS_BIT];
        d.eep_prot = nv[nvm_seq_pkg::EEP_BIT];
      end else if (I_ADDRESS == nvm_seq_pkg::A_PROT) begin
        d.prot_base = nv[16:0];
      end
    end

    if (launch) begin
      if (acc_c | fpv_c) begin
        d.access_error_flag = acc_c;
        d.protection_violation_flag = fpv_c;
      end else begin
        d.ccf        = 1'b0;
        d.mgstat     = 2'h0;
        d.arr.req    = 1'b1;
        d.arr.lw2    = q.idx == nvm_seq_pkg::IDX_5;
        d.arr.wdata  = q.words[5:2];
        d.arr.addr   = {21'h0, q.words[1][2:0]};
        d.once       = is_ro | is_po;
        if (is_ro) begin
          d.arr.op = nvm_seq_pkg::OP_ONCE_READ;
          d.st     = nvm_seq_pkg::S_ONCE_RD;
        end else if (is_pf) begin
          d.arr.addr = gaddr;
          d.arr.op   = nvm_seq_pkg::OP_PROG;
          d.st       = nvm_seq_pkg::S_PROG;
        end else if (is_po) begin
          d.arr.op = nvm_seq_pkg::OP_ONCE_BLANK;
          d.st     = nvm_seq_pkg::S_BLANKCHK;
        end else begin
          d.arr.op = nvm_seq_pkg::OP_ERASE_ALL;
          d.st     = nvm_seq_pkg::S_ERASE;
        end
      end
    end

    if (ack) begin
      d.arr.req = 1'b0;
      case (q.st)
        nvm_seq_pkg::S_ONCE_RD: begin
          d.words[5:2] = I_ARR.rdata;
          d.mgstat = {I_ARR.err | I_ARR.fatal, I_ARR.fatal};
          d.st     = nvm_seq_pkg::S_IDLE;
        end
        nvm_seq_pkg::S_BLANKCHK: begin
          if (I_ARR.err | I_ARR.fatal) begin
            d.access_error_flag = 1'b1;
            d.st     = nvm_seq_pkg::S_IDLE;
          end else begin
            d.arr.req = 1'b1;
            d.arr.op  = nvm_seq_pkg::OP_ONCE_PROG;
            d.st      = nvm_seq_pkg::S_PROG;
          end
        end
        nvm_seq_pkg::S_PROG: begin
          d.arr.req = 1'b1;
          d.arr.op  = q.once ? nvm_seq_pkg::OP_ONCE_READ
                             : nvm_seq_pkg::OP_READ;
          d.st      = nvm_seq_pkg::S_VERIFY;
        end
        nvm_seq_pkg::S_VERIFY: begin
          mism = q.arr.lw2 ? (I_ARR.rdata != q.arr.wdata)
               : (I_ARR.rdata[31:0] != q.arr.wdata[31:0]);
          d.mgstat = {mism | I_ARR.err | I_ARR.fatal,
                      I_ARR.fatal};
          d.st     = nvm_seq_pkg::S_IDLE;
        end
        nvm_seq_pkg::S_ERASE: begin
          d.arr.req = 1'b1;
          d.arr.op  = nvm_seq_pkg::OP_BLANK_ALL;
          d.st      = nvm_seq_pkg::S_BLANK;
        end
        nvm_seq_pkg::S_BLANK: begin
          d.mgstat = {I_ARR.err | I_ARR.fatal, I_ARR.fatal};
          if (~I_ARR.err & ~I_ARR.fatal) begin
            d.secured = 1'b0;
          end
          d.st = nvm_seq_pkg::S_IDLE;
        end
        default: begin
          d.st = nvm_seq_pkg::S_IDLE;
        end
      endcase
      if (d.st == nvm_seq_pkg::S_IDLE) begin
        d.ccf  = 1'b1;
        d.once = 1'b0;
      end
    end

    d.cpu_rd = (q.once & ~q.ccf) ? nvm_seq_pkg::INVALID_RD
                                 : I_CPU_RDATA;
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      q           <= '0;
      q.waitreq   <= 1'b1;
      q.ccf       <= 1'b1;
      q.prot_base <= FLASH_SIZE;
      q.secured   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign O_READDATA    = q.rdata;
  assign O_WAITREQUEST = q.waitreq;
  assign O_ARR         = q.arr;
  assign O_CPU_RDATA   = q.cpu_rd;
  assign O_SECURED     = q.secured;

  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESETN);

  a_once_rd_idx: assert property (
    launch && is_ro && q.idx != nvm_seq_pkg::IDX_1
    |=> q.access_error_flag && q.ccf && !q.arr.req)
    else $error("read once with wrong index not refused");

  a_once_rd_fill: assert property (
    ack && q.st == nvm_seq_pkg::S_ONCE_RD
    |=> q.words[5:2] == $past(I_ARR.rdata) && q.ccf)
    else $error("read once data not stored");

  a_once_area: assert property (
    q.arr.req && q.once |-> q.arr.addr < nvm_seq_pkg::ONCE_PHRASES)
    else $error("one-time access outside area");

  a_phrase_rng: assert property (
    launch && (is_ro || is_po) && bad_ph |=> q.access_error_flag)
    else $error("bad phrase index accepted");

  a_rd_invalid: assert property (
    q.once && !q.ccf |=> O_CPU_RDATA == nvm_seq_pkg::INVALID_RD)
    else $error("flash read valid during one-time command");

  a_rd_status: assert property (
    ack && q.st == nvm_seq_pkg::S_ONCE_RD && I_ARR.fatal
    |=> q.mgstat == 2'h3)
    else $error("read once fatal error not reported");

  a_ccf_busy: assert property (
    launch && !acc_c && !fpv_c |=> !q.ccf ##1 !q.ccf)
    else $error("complete flag not held clear");

  a_prog_chk: assert property (
    launch && is_pf && (gaddr[1:0] != 2'h0 || past_end)
    |=> q.access_error_flag && !q.arr.req)
    else $error("bad program address accepted");

  a_protect: assert property (
    launch && fpv_c |=> q.protection_violation_flag && q.ccf && !q.arr.req)
    else $error("protected target not refused");

  a_verify: assert property (
    ack && q.st == nvm_seq_pkg::S_VERIFY &&
    I_ARR.rdata[31:0] != q.arr.wdata[31:0]
    |=> q.mgstat[1] && q.ccf)
    else $error("verify mismatch not reported");

  a_once_twice: assert property (
    ack && q.st == nvm_seq_pkg::S_BLANKCHK && I_ARR.err
    |=> q.access_error_flag && q.ccf && !q.arr.req)
    else $error("second one-time program not refused");

  a_unsecure: assert property (
    $fell(q.secured) |-> $rose(q.ccf) && q.mgstat == 2'h0)
    else $error("security released without clean erase");

  a_mode: assert property (
    launch && q.cmd_dis |=> q.access_error_flag && q.ccf)
    else $error("disallowed command accepted");

  a_prog_idx: assert property (
    launch && is_pf && q.idx != nvm_seq_pkg::IDX_3 &&
    q.idx != nvm_seq_pkg::IDX_5 |=> q.access_error_flag && !q.arr.req)
    else $error("program with wrong index not refused");

  a_eep_target: assert property (
    launch && is_pf && gaddr[nvm_seq_pkg::EEP_SEL_BIT]
    |=> q.access_error_flag && !q.arr.req)
    else $error("program to EEPROM block accepted");

  a_once_prog_idx: assert property (
    launch && is_po && q.idx != nvm_seq_pkg::IDX_5
    |=> q.access_error_flag && q.ccf && !q.arr.req)
    else $error("program once with wrong index not refused");

  a_blank_first: assert property (
    ack && q.st == nvm_seq_pkg::S_BLANKCHK && !I_ARR.err && !I_ARR.fatal
    |=> q.arr.req && q.arr.op == nvm_seq_pkg::OP_ONCE_PROG)
    else $error("blank phrase not programmed");

  a_erase_idx: assert property (
    launch && is_ea && q.idx != nvm_seq_pkg::IDX_0
    |=> q.access_error_flag && q.ccf && !q.arr.req)
    else $error("erase all with wrong index not refused");

  a_erase_prot: assert property (
    launch && is_ea && !acc_c &&
    (q.eep_prot || q.prot_base != FLASH_SIZE) |=> q.protection_violation_flag && q.ccf)
    else $error("erase all under protection accepted");

  a_reject_idle: assert property (
    launch && (acc_c || fpv_c) |=> q.ccf && !q.arr.req)
    else $error("rejected command started");

endmodule : nvm_program_once_erase_cmds

`default_nettype wire

// ==== common/nvm_seq_pkg.sv ====
package nvm_seq_pkg;

  localparam int AW = 5;

  // Register byte offsets
  localparam logic [AW-1:0] A_STATUS = 5'h00;
  localparam logic [AW-1:0] A_INDEX  = 5'h04;
  localparam logic [AW-1:0] A_OBJ_HI = 5'h08;
  localparam logic [AW-1:0] A_OBJ_LO = 5'h0C;
  localparam logic [AW-1:0] A_CONFIG = 5'h10;
  localparam logic [AW-1:0] A_PROT   = 5'h14;
  localparam logic [AW-1:0] A_SECURE = 5'h18;

  // Status register bit positions
  localparam int CCF_BIT = 7;
  localparam int ACC_BIT = 5;
  localparam int FPV_BIT = 4;

  // Config register bit positions
  localparam int DIS_BIT = 0;
  localparam int EEP_BIT = 1;

  localparam logic [7:0] CMD_READ_ONCE = 8'h04;
  localparam logic [7:0] CMD_PROG      = 8'h06;
  localparam logic [7:0] CMD_PROG_ONCE = 8'h07;
  localparam logic [7:0] CMD_ERASE_ALL = 8'h08;

  localparam logic [2:0] IDX_0 = 3'h0;
  localparam logic [2:0] IDX_1 = 3'h1;
  localparam logic [2:0] IDX_3 = 3'h3;
  localparam logic [2:0] IDX_5 = 3'h5;

  localparam logic [15:0] ONCE_LAST    = 16'h0007;
  localparam logic [23:0] ONCE_PHRASES = 24'h000008;
  localparam int          EEP_SEL_BIT  = 23;
  localparam logic [16:0] LW1_BYTES    = 17'h00004;
  localparam logic [16:0] LW2_BYTES    = 17'h00008;
  localparam logic [7:0]  INVALID_RD   = 8'hFF;

  typedef enum logic [2:0] {
    OP_NONE, OP_READ, OP_PROG, OP_ONCE_READ, OP_ONCE_PROG,
    OP_ONCE_BLANK, OP_ERASE_ALL, OP_BLANK_ALL
  } arr_op_t;

  typedef enum logic [2:0] {
    S_IDLE, S_ONCE_RD, S_BLANKCHK, S_PROG, S_VERIFY, S_ERASE, S_BLANK
  } st_t;

  typedef struct packed {
    logic        req;
    arr_op_t     op;
    logic        lw2;
    logic [23:0] addr;
    logic [63:0] wdata;
  } arr_req_t;

  typedef struct packed {
    logic        ack;
    logic        err;
    logic        fatal;
    logic [63:0] rdata;
  } arr_rsp_t;

  typedef struct packed {
    st_t              st;
    logic             waitreq;
    logic [31:0]      rdata;
    logic             ccf;
    logic             access_error_flag;
    logic             protection_violation_flag;
    logic [1:0]       mgstat;
    logic [2:0]       idx;
    logic [5:0][15:0] words;
    logic             cmd_dis;
    logic             eep_prot;
    logic [16:0]      prot_base;
    logic             secured;
    logic             once;
    logic [7:0]       cpu_rd;
    arr_req_t         arr;
  } ctl_t;

endpackage : nvm_seq_pkg

// ==== testbench/nvm_array_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Flash and one-time array stand-in with an adjustable answer delay
module nvm_array_model (
  input  wire logic                  i_clk,
  input  wire logic                  i_resetn,
  input  wire nvm_seq_pkg::arr_req_t i_req,
  output nvm_seq_pkg::arr_rsp_t      o_rsp,
  input  wire logic [3:0]            i_delay,
  input  wire logic                  i_err,
  input  wire logic                  i_fatal,
  input  wire logic                  i_flip
);
  logic [3:0]  cnt;
  logic        ack_q;
  logic        err_q;
  logic        fat_q;
  logic [63:0] rd_q;
  logic [63:0] last_w;
  logic [63:0] mem [64] = '{default: '1};
  logic [63:0] once_m [8] = '{default: '1};
  logic [7:0]  once_used = 8'h00;
  int          n_ops = 0;
  logic [2:0]  ph;

  assign ph = i_req.addr[2:0];
  // Released lines show the inverse of the last answer
  assign o_rsp = '{ack: ack_q, err: ack_q ? err_q : ~err_q,
                   fatal: ack_q ? fat_q : ~fat_q,
                   rdata: ack_q ? rd_q : ~rd_q};

  always @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      cnt <= 4'h0;
      ack_q <= 1'b0;
      err_q <= 1'b0;
      fat_q <= 1'b0;
      rd_q <= 64'h0;
    end else begin
      ack_q <= 1'b0;
      if (!i_req.req || ack_q) cnt <= 4'h0;
      else if (cnt < i_delay) cnt <= cnt + 4'h1;
      else begin
        cnt <= 4'h0;
        ack_q <= 1'b1;
        err_q <= 1'b0;
        fat_q <= 1'b0;
        n_ops <= n_ops + 1;
        case (i_req.op)
          nvm_seq_pkg::OP_PROG: begin
            mem[i_req.addr[7:2]] <= i_req.wdata;
            last_w <= i_req.wdata;
          end
          nvm_seq_pkg::OP_READ: begin
            rd_q <= mem[i_req.addr[7:2]] ^ {63'h0, i_flip};
            err_q <= i_err;
            fat_q <= i_fatal;
          end
          nvm_seq_pkg::OP_ONCE_BLANK: err_q <= once_used[ph];
          nvm_seq_pkg::OP_ONCE_PROG: begin
            once_m[ph] <= i_req.wdata;
            once_used[ph] <= 1'b1;
          end
          nvm_seq_pkg::OP_ONCE_READ: begin
            rd_q <= once_m[ph];
            err_q <= i_err;
            fat_q <= i_fatal;
          end
          nvm_seq_pkg::OP_ERASE_ALL: begin
            for (int i = 0; i < 64; i++) begin
              mem[i] <= '1;
            end
          end
          nvm_seq_pkg::OP_BLANK_ALL: begin
            err_q <= i_err;
            fat_q <= i_fatal;
          end
          default: ;
        endcase
      end
    end
  end
endmodule : nvm_array_model
`default_nettype wire

// ==== testbench/tb_nvm_program_once_erase_cmds.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_nvm_program_once_erase_cmds;
  logic                  clk = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  rd_en = 1'b0;
  logic                  wr_en = 1'b0;
  logic                  wreq;
  logic                  secured;
  logic [4:0]            adr = 5'h00;
  logic [31:0]           wdat = 32'h0;
  logic [31:0]           rdat;
  logic [31:0]           q;
  logic [31:0]           seed = 32'hA0BB;
  logic [31:0]           cseed = 32'h1234;
  logic [7:0]            cpu_in = 8'h00;
  logic [7:0]            cpu_out;
  logic [7:0]            hb;
  logic [3:0]            dly = 4'h0;
  logic                  ferr = 1'b0;
  logic                  ffat = 1'b0;
  logic                  flip = 1'b0;
  logic [5:0][15:0]      w = '0;
  logic [5:0][15:0]      pw;
  logic [7:0]            cmds [4] = '{8'h04, 8'h06, 8'h07, 8'h08};
  logic [2:0]            bad [4] = '{3'h0, 3'h4, 3'h3, 3'h1};
  nvm_seq_pkg::arr_req_t arr_q;
  nvm_seq_pkg::arr_rsp_t rsp;
  int                    miscompares = 0;
  int                    n_checks = 0;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsr

  function automatic logic [31:0] exp_st(input logic acc, input logic fpv,
                                         input logic [1:0] ms);
    return {24'h0, 1'b1, 1'b0, acc, fpv, 2'b00, ms};
  endfunction : exp_st

  always #50 clk = ~clk;
  always @(posedge clk) begin
    cseed <= lfsr(cseed);
    cpu_in <= cseed[7:0];
  end

  nvm_program_once_erase_cmds #(.FLASH_SIZE(17'h00100)) dut_u (
    .I_CLK(clk), .I_RESETN(rst_n), .I_ADDRESS(adr), .I_READ(rd_en),
    .I_WRITE(wr_en), .I_WRITEDATA(wdat), .I_BYTEENABLE(4'hF),
    .O_READDATA(rdat), .O_WAITREQUEST(wreq), .O_ARR(arr_q), .I_ARR(rsp),
    .I_CPU_RDATA(cpu_in), .O_CPU_RDATA(cpu_out), .O_SECURED(secured));

  nvm_array_model mdl_u (
    .i_clk(clk), .i_resetn(rst_n), .i_req(arr_q), .o_rsp(rsp),
    .i_delay(dly), .i_err(ferr), .i_fatal(ffat), .i_flip(flip));

  task automatic give_verdict;
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // One Avalon access; read data lands in q
  task automatic bus(input logic wn, input logic [4:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    adr <= a;
    wr_en <= wn;
    rd_en <= !wn;
    wdat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wreq !== 1'b0 && n < 50);
    q = rdat;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    if (n >= 50) begin
      miscompares++;
      give_verdict();
    end
  endtask : bus

  task automatic start(input logic [2:0] last);
    for (int i = 0; i <= int'(last); i++) begin
      bus(1'b1, nvm_seq_pkg::A_INDEX, 32'(i));
      bus(1'b1, nvm_seq_pkg::A_OBJ_HI, {24'h0, w[i][15:8]});
      bus(1'b1, nvm_seq_pkg::A_OBJ_LO, {24'h0, w[i][7:0]});
    end
    bus(1'b1, nvm_seq_pkg::A_STATUS, 32'h00000080);
  endtask : start

  // Only reads while busy, then clears the error flags
  task automatic finish(input logic [31:0] exp);
    int n;
    n = 0;
    do begin
      bus(1'b0, nvm_seq_pkg::A_STATUS, 32'h0);
      n++;
    end while (q[7] !== 1'b1 && n < 100);
    if (n >= 100) begin
      miscompares++;
      give_verdict();
    end
    chk(q, exp);
    bus(1'b1, nvm_seq_pkg::A_STATUS, 32'h00000030);
  endtask : finish

  task automatic reject(input logic [2:0] last, input logic [31:0] exp);
    int ops;
    ops = mdl_u.n_ops;
    start(last);
    finish(exp);
    chk(32'(mdl_u.n_ops), 32'(ops));
  endtask : reject

  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    bus(1'b0, nvm_seq_pkg::A_STATUS, 32'h0);
    chk(q, exp_st(1'b0, 1'b0, 2'b00));
    chk({31'h0, secured}, 32'h1);
    @(posedge clk);
    hb = cpu_in;
    @(posedge clk);
    chk({24'h0, cpu_out}, {24'h0, hb});
    bus(1'b0, 5'h1C, 32'h0);
    chk(q, 32'h0);
    for (int k = 0; k < 4; k++) begin
      w[0] = {cmds[k], 8'h00};
      reject(bad[k], exp_st(1'b1, 1'b0, 2'b00));
    end
    w[0] = 16'h0400;
    w[1] = 16'h0008;
    reject(3'h1, exp_st(1'b1, 1'b0, 2'b00));
    w[0] = 16'h0700;
    reject(3'h5, exp_st(1'b1, 1'b0, 2'b00));
    w[0] = 16'h0600;
    w[1] = 16'h0012;
    reject(3'h5, exp_st(1'b1, 1'b0, 2'b00));
    w[1] = 16'h00FC;
    reject(3'h5, exp_st(1'b1, 1'b0, 2'b00));
    w[0] = 16'h0680;
    w[1] = 16'h0010;
    reject(3'h3, exp_st(1'b1, 1'b0, 2'b00));
    bus(1'b1, nvm_seq_pkg::A_CONFIG, 32'h1);
    w[0] = 16'h0800;
    reject(3'h0, exp_st(1'b1, 1'b0, 2'b00));
    bus(1'b1, nvm_seq_pkg::A_CONFIG, 32'h2);
    reject(3'h0, exp_st(1'b0, 1'b1, 2'b00));
    bus(1'b1, nvm_seq_pkg::A_CONFIG, 32'h0);
    bus(1'b1, nvm_seq_pkg::A_PROT, 32'h80);
    reject(3'h0, exp_st(1'b0, 1'b1, 2'b00));
    w[0] = 16'h0600;
    w[1] = 16'h0080;
    reject(3'h3, exp_st(1'b0, 1'b1, 2'b00));
    bus(1'b1, nvm_seq_pkg::A_PROT, 32'h100);
    for (int k = 0; k < 6; k++) begin
      w[1] = 16'(8 * k);
      for (int j = 2; j < 6; j++) begin
        seed = lfsr(seed);
        w[j] = seed[15:0];
      end
      dly <= {2'b00, seed[17:16]};
      ferr <= (k == 4);
      ffat <= (k == 5);
      flip <= (k == 3);
      start(seed[20] ? 3'h5 : 3'h3);
      finish(exp_st(1'b0, 1'b0, {k >= 3, k == 5}));
      chk(mdl_u.last_w[31:0], {w[3], w[2]});
    end
    dly <= 4'h6;
    ferr <= 1'b0;
    ffat <= 1'b0;
    flip <= 1'b0;
    w[0] = 16'h0700;
    w[1] = 16'h0003;
    pw = w;
    start(3'h5);
    bus(1'b0, nvm_seq_pkg::A_STATUS, 32'h0);
    chk(q & 32'h80, 32'h0);
    chk({24'h0, cpu_out}, 32'hFF);
    finish(exp_st(1'b0, 1'b0, 2'b00));
    w[0] = 16'h0400;
    start(3'h1);
    repeat (2) @(posedge clk);
    chk({24'h0, cpu_out}, 32'hFF);
    finish(exp_st(1'b0, 1'b0, 2'b00));
    for (int j = 2; j < 6; j++) begin
      bus(1'b1, nvm_seq_pkg::A_INDEX, 32'(j));
      bus(1'b0, nvm_seq_pkg::A_OBJ_HI, 32'h0);
      hb = q[7:0];
      bus(1'b0, nvm_seq_pkg::A_OBJ_LO, 32'h0);
      chk({16'h0, hb, q[7:0]}, {16'h0, pw[j]});
    end
    w = pw;
    start(3'h5);
    finish(exp_st(1'b1, 1'b0, 2'b00));
    w[0] = 16'h0400;
    w[1] = 16'h0002;
    ferr <= 1'b1;
    start(3'h1);
    finish(exp_st(1'b0, 1'b0, 2'b10));
    ferr <= 1'b0;
    ffat <= 1'b1;
    start(3'h1);
    finish(exp_st(1'b0, 1'b0, 2'b11));
    ffat <= 1'b0;
    w[0] = 16'h0800;
    start(3'h0);
    finish(exp_st(1'b0, 1'b0, 2'b00));
    chk({31'h0, secured}, 32'h0);
    give_verdict();
  end
endmodule : tb_nvm_program_once_erase_cmds
`default_nettype wire
